/* rtl/ctl_pkg.sv */
// Shared constants, types and helpers for the charge termination logic
`default_nettype none
package ctl_pkg;

   // System clock
   localparam longint CLK_HZ           = 64'd50000000;

   // Times in their own units
   localparam longint SCK_HZ           = 64'd95000;
   localparam longint VFC_HZ_PER_VOLT  = 64'd24000;
   localparam longint GATE_PERIOD_MS   = 64'd1380;
   localparam longint GATE_LOW_MS      = 64'd33;
   localparam longint PRESET_MS        = 64'd11;
   localparam longint CONVERT_MS       = 64'd22;
   localparam longint START_MS         = 64'd60;
   localparam longint HOLD_SHORT_S     = 64'd177;
   localparam longint HOLD_LONG_S      = 64'd708;
   localparam longint MINUTE_S         = 64'd60;

   // Derived cycle counts
   localparam logic [15:0] SCK_HALF_CYC     = 16'(CLK_HZ / (64'd2 * SCK_HZ));
   localparam logic [31:0] GATE_PERIOD_CYC  = 32'(CLK_HZ * GATE_PERIOD_MS / 64'd1000);
   localparam logic [31:0] GATE_LOW_CYC     = 32'(CLK_HZ * GATE_LOW_MS / 64'd1000);
   localparam logic [31:0] PRESET_CYC       = 32'(CLK_HZ * PRESET_MS / 64'd1000);
   localparam logic [31:0] CONVERT_CYC      = 32'(CLK_HZ * CONVERT_MS / 64'd1000);
   localparam logic [39:0] START_CYC        = 40'(CLK_HZ * START_MS / 64'd1000);
   localparam logic [39:0] HOLD_SHORT_CYC   = 40'(CLK_HZ * HOLD_SHORT_S);
   localparam logic [39:0] HOLD_LONG_CYC    = 40'(CLK_HZ * HOLD_LONG_S);
   localparam logic [31:0] MINUTE_CYC       = 32'(CLK_HZ * MINUTE_S);

   // Ratchet counter: 2.0 V range over 1023 steps
   localparam int          RATCHET_W        = 10;
   localparam logic [9:0]  RATCHET_MAX      = 10'h3ff;
   localparam logic [9:0]  DROP_COUNTS      = 10'h002;

   // Backup time limits in minutes
   localparam logic [8:0]  LIMIT_111        = 9'h11b;  // 283
   localparam logic [8:0]  LIMIT_110        = 9'h0f7;  // 247
   localparam logic [8:0]  LIMIT_101        = 9'h0d4;  // 212
   localparam logic [8:0]  LIMIT_100        = 9'h0b1;  // 177
   localparam logic [8:0]  LIMIT_011        = 9'h08d;  // 141
   localparam logic [8:0]  LIMIT_010        = 9'h06a;  // 106
   localparam logic [8:0]  LIMIT_001        = 9'h047;  // 71
   localparam logic [8:0]  LIMIT_NONE       = 9'h1ff;

   typedef enum logic [1:0] {
      CTL_PH_IDLE    = 2'b00,
      CTL_PH_PRESET  = 2'b01,
      CTL_PH_CONVERT = 2'b10
   } ctl_phase_t;

   // Code is {low_ref, sense, high_ref}, open reads as one
   function automatic logic [8:0] ctl_limit_min(input logic [2:0] code);
      logic [8:0] lim;
      lim = LIMIT_NONE;
      case (code)
         3'h7:    lim = LIMIT_111;
         3'h6:    lim = LIMIT_110;
         3'h5:    lim = LIMIT_101;
         3'h4:    lim = LIMIT_100;
         3'h3:    lim = LIMIT_011;
         3'h2:    lim = LIMIT_010;
         3'h1:    lim = LIMIT_001;
         default: lim = LIMIT_NONE;
      endcase
      return lim;
   endfunction

endpackage
`default_nettype wire

/* rtl/ctl_link_if.sv */
// Internal links between the controller and its sample and backup timers
`default_nettype none
interface ctl_link_if;
   logic       sck_tick;
   logic       preset;
   logic       convert;
   logic       conv_done;
   logic       gate_low;
   logic       bt_clear;
   logic       bt_run;
   logic [2:0] bt_code;
   logic       bt_expired;

   modport st_src (output sck_tick, output preset, output convert,
                   output conv_done, output gate_low);
   modport st_snk (input sck_tick, input preset, input convert,
                   input conv_done, input gate_low);
   modport bt_dev (input bt_clear, input bt_run, input bt_code, output bt_expired);
   modport bt_ctl (output bt_clear, output bt_run, output bt_code, input bt_expired);
endinterface
`default_nettype wire

/* rtl/ctl_sample_timer.sv */
// Sample clock divider and gate / preload / convert sequencer
`default_nettype none
module ctl_sample_timer
   import ctl_pkg::*;
#(
   parameter logic [31:0] P_PERIOD_CYC  = GATE_PERIOD_CYC,
   parameter logic [31:0] P_PRESET_CYC  = PRESET_CYC,
   parameter logic [31:0] P_CONVERT_CYC = CONVERT_CYC
) (
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   ctl_link_if.st_src  lnk,
   output logic        o_sck
);
   logic [15:0] div_reg,   div_next;
   logic        sck_reg,   sck_next;
   logic        tick_reg,  tick_next;
   logic [31:0] per_reg,   per_next;
   ctl_phase_t  ph_reg,    ph_next;
   logic        done_reg,  done_next;

   always_comb begin
      div_next  = div_reg + 16'h0001;
      sck_next  = sck_reg;
      tick_next = 1'b0;
      if (div_reg == SCK_HALF_CYC - 16'h0001) begin  // RQ1
         div_next  = 16'h0000;
         sck_next  = ~sck_reg;
         tick_next = ~sck_reg;
      end
      per_next  = (per_reg == P_PERIOD_CYC - 32'h1) ? 32'h0 : per_reg + 32'h1;  // RQ3
      ph_next   = ph_reg;
      done_next = 1'b0;
      case (ph_reg)
         CTL_PH_IDLE: begin
            if (per_next == 32'h0)
               ph_next = CTL_PH_PRESET;  // RQ3
         end
         CTL_PH_PRESET: begin
            if (per_reg == P_PRESET_CYC - 32'h1)
               ph_next = CTL_PH_CONVERT;  // RQ4
         end
         CTL_PH_CONVERT: begin
            if (per_reg == P_PRESET_CYC + P_CONVERT_CYC - 32'h1) begin  // RQ5
               ph_next   = CTL_PH_IDLE;
               done_next = 1'b1;
            end
         end
         default: ph_next = CTL_PH_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_reg  <= 16'h0000;
         sck_reg  <= 1'b0;
         tick_reg <= 1'b0;
         per_reg  <= 32'h0;
         ph_reg   <= CTL_PH_PRESET;
         done_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         sck_reg  <= sck_next;
         tick_reg <= tick_next;
         per_reg  <= per_next;
         ph_reg   <= ph_next;
         done_reg <= done_next;
      end
   end

   assign o_sck         = sck_reg;
   assign lnk.sck_tick  = tick_reg;
   assign lnk.preset    = (ph_reg == CTL_PH_PRESET);
   assign lnk.convert   = (ph_reg == CTL_PH_CONVERT);
   assign lnk.gate_low  = (ph_reg != CTL_PH_IDLE);
   assign lnk.conv_done = done_reg;
endmodule
`default_nettype wire

/* rtl/ctl_backup_timer.sv */
// Programmable fast charge backup timer, minute resolution
`default_nettype none
module ctl_backup_timer
   import ctl_pkg::*;
#(
   parameter logic [31:0] P_MINUTE_CYC = MINUTE_CYC
) (
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   ctl_link_if.bt_dev  lnk
);
   logic [31:0] pre_reg, pre_next;
   logic [8:0]  min_reg, min_next;
   logic        exp_reg, exp_next;
   logic [8:0]  limit;

   always_comb begin
      limit    = ctl_limit_min(lnk.bt_code);  // RQ16 RQ17
      pre_next = pre_reg;
      min_next = min_reg;
      if (lnk.bt_run) begin  // RQ26
         pre_next = pre_reg + 32'h1;
         if (pre_reg == P_MINUTE_CYC - 32'h1) begin
            pre_next = 32'h0;
            if (min_reg != 9'h1ff)
               min_next = min_reg + 9'h001;
         end
      end
      // Set wins over a simultaneous clear
      exp_next = exp_reg & ~lnk.bt_clear;
      // Only a running timer expires, so a stale count cannot beat a clear
      if (lnk.bt_run && (lnk.bt_code != 3'h0) && (min_reg >= limit))  // RQ18 RQ19
         exp_next = 1'b1;
      if (lnk.bt_clear) begin  // RQ26
         pre_next = 32'h0;
         min_next = 9'h000;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_reg <= 32'h0;
         min_reg <= 9'h000;
         exp_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         min_reg <= min_next;
         exp_reg <= exp_next;
      end
   end

   assign lnk.bt_expired = exp_reg;
endmodule
`default_nettype wire

/* rtl/ctl_charge_term.sv */
// Charge termination controller: negative slope, backup limits, fast/trickle
// Functional notes
// [RQ1] Sample timer drives a roughly 95 kHz sample clock to the converter.
// [RQ2] Converter pulses are counted only on sample clock edges, keeping them synchronous.
// [RQ3] Every 1.38 s the sense gate pulls low for 33 ms.
// [RQ4] Gate low starts an 11 ms preload phase that clears the ratchet count to zero.
// [RQ5] After preload, a 22 ms conversion window counts converter pulses.
// [RQ6] A conversion above the peak becomes the new peak.
// [RQ7] A conversion two counts under peak flags the first below-peak event.
// [RQ8] Two successive below-peak events assert slope detect and latch trickle.
// [RQ9] Slope sampling starts after 60 ms of fast charge.
// [RQ10] Slope detect affects the rate output only after holdoff elapses.
// [RQ11] Holdoff is 177 s, or 708 s for the long variant.
// [RQ12] A drop in holdoff followed by a rise clears slope detect and stays in fast mode.
// [RQ13] A drop in holdoff never recovered latches trickle at holdoff end.
// [RQ14] Ratchet count is ten bits, saturating at 1023.
// [RQ15] Any program input high selects timer mode.
// [RQ16] Timer mode picks one of seven time limits from the inputs.
// [RQ17] Limits are 283 down to 71 minutes by input code.
// [RQ18] Exceeding the time limit latches trickle mode.
// [RQ19] All program inputs low disables timer, selects temperature window.
// [RQ20] Cold pack forces trickle while the comparator reports cold.
// [RQ21] Over-temperature sets a latch that holds trickle mode.
// [RQ22] Over-temperature latch clears only on a reset event.
// [RQ23] Sense entering its window returns fast and pulses reset to timers; an entry while slope detect is set after holdoff keeps trickle latched.
// [RQ24] Sense below 1.0 V resets the slope detection logic.
// [RQ25] Power-up starts in fast mode with all counts cleared.
// [RQ26] Holdoff and backup timers run only in fast mode, restart on reset.
`default_nettype none
module ctl_charge_term
   import ctl_pkg::*;
#(
   parameter bit          P_LONG_HOLDOFF  = 1'b0,
   parameter logic [31:0] P_PERIOD_CYC    = GATE_PERIOD_CYC,
   parameter logic [31:0] P_PRESET_CYC    = PRESET_CYC,
   parameter logic [31:0] P_CONVERT_CYC   = CONVERT_CYC,
   parameter logic [39:0] P_START_CYC     = START_CYC,
   parameter logic [39:0] P_HOLD_CYC      = P_LONG_HOLDOFF ? HOLD_LONG_CYC : HOLD_SHORT_CYC,
   parameter logic [31:0] P_MINUTE_CYC    = MINUTE_CYC
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_VFC_PULSE,
   input  wire logic        I_SENSE_IN_WINDOW,
   input  wire logic        I_SENSE_UNDER,
   input  wire logic        I_LOW_REF_PROG_HIGH,
   input  wire logic        I_SENSE_PROG_HIGH,
   input  wire logic        I_HIGH_REF_PROG_HIGH,
   input  wire logic        I_UNDER_TEMP,
   input  wire logic        I_OVER_TEMP,
   output logic             O_SAMPLE_CLK,
   output logic             O_SENSE_GATE_OUT,
   output logic             O_SENSE_GATE_OE,
   output logic             O_FAST_TRICKLE_OUT,
   output logic             O_FAST_TRICKLE_OE,
   output logic             O_NEG_SLOPE,
   output logic             O_FIRST_EVENT,
   output logic             O_TIMER_MODE,
   output logic             O_OVER_TEMP_LATCHED,
   output logic [9:0]       O_PEAK_COUNT
);

   ctl_link_if lnk ();

   ctl_sample_timer #(
      .P_PERIOD_CYC  (P_PERIOD_CYC),
      .P_PRESET_CYC  (P_PRESET_CYC),
      .P_CONVERT_CYC (P_CONVERT_CYC)
   ) u_sample (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .lnk   (lnk.st_src),
      .o_sck (O_SAMPLE_CLK)
   );

   ctl_backup_timer #(
      .P_MINUTE_CYC (P_MINUTE_CYC)
   ) u_backup (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .lnk   (lnk.bt_dev)
   );

   // Programming inputs and mode select
   logic [2:0] prog_code;
   logic       time_mode;
   logic       temp_mode;

   assign prog_code = {I_LOW_REF_PROG_HIGH, I_SENSE_PROG_HIGH, I_HIGH_REF_PROG_HIGH};
   assign time_mode = |prog_code;  // RQ15
   assign temp_mode = ~time_mode;  // RQ19

   // Window entry detection and reset event
   logic win_prev_reg, win_prev_next;
   logic rst_evt;

   always_comb begin
      win_prev_next = I_SENSE_IN_WINDOW;
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST)
         win_prev_reg <= 1'b0;
      else
         win_prev_reg <= win_prev_next;
   end

   assign rst_evt = I_SENSE_IN_WINDOW & ~win_prev_reg;  // RQ23

   // Over-temperature latch
   logic ot_reg, ot_next;

   always_comb begin
      // Set wins over a reset event in the same cycle
      ot_next = (ot_reg & ~rst_evt) | (temp_mode & I_OVER_TEMP);  // RQ21 RQ22
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST)
         ot_reg <= 1'b0;  // RQ22
      else
         ot_reg <= ot_next;
   end

   // Fast charge time counter: start delay and holdoff
   logic [39:0] hold_reg, hold_next;
   logic        fast_reg, fast_next;
   logic        started;
   logic        hold_done;

   assign started   = (hold_reg >= P_START_CYC);  // RQ9
   assign hold_done = (hold_reg >= P_HOLD_CYC);   // RQ10 RQ11

   always_comb begin
      hold_next = hold_reg;
      if (rst_evt)
         hold_next = 40'h0;  // RQ26
      else if (fast_reg && !hold_done)
         hold_next = hold_reg + 40'h1;  // RQ26
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST)
         hold_reg <= 40'h0;  // RQ25
      else
         hold_reg <= hold_next;
   end

   // Ratchet counter fed by synchronous converter pulses
   logic [9:0] rat_reg,  rat_next;
   logic       vfc_prev_reg, vfc_prev_next;
   logic       vfc_edge;

   assign vfc_edge = lnk.sck_tick & I_VFC_PULSE & ~vfc_prev_reg;  // RQ2

   always_comb begin
      vfc_prev_next = lnk.sck_tick ? I_VFC_PULSE : vfc_prev_reg;  // RQ2
      rat_next      = rat_reg;
      if (lnk.preset)
         rat_next = 10'h000;  // RQ4
      else if (lnk.convert && vfc_edge && rat_reg != RATCHET_MAX)
         rat_next = rat_reg + 10'h001;  // RQ5 RQ14
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         rat_reg      <= 10'h000;
         vfc_prev_reg <= 1'b0;
      end else begin
         rat_reg      <= rat_next;
         vfc_prev_reg <= vfc_prev_next;
      end
   end

   // Peak tracking and below-peak events
   logic [9:0] peak_reg,  peak_next;
   logic       first_reg, first_next;
   logic       nslope_reg, nslope_next;
   logic       below_peak;

   assign below_peak = (peak_reg >= DROP_COUNTS) && (rat_reg <= peak_reg - DROP_COUNTS);

   always_comb begin
      peak_next   = peak_reg;
      first_next  = first_reg;
      nslope_next = nslope_reg;
      if (I_SENSE_UNDER || rst_evt) begin  // RQ24
         peak_next   = 10'h000;
         first_next  = 1'b0;
         nslope_next = 1'b0;
      end else if (lnk.conv_done && started) begin  // RQ9
         if (rat_reg > peak_reg) begin
            peak_next   = rat_reg;  // RQ6
            first_next  = 1'b0;
            nslope_next = 1'b0;     // RQ12
         end else if (below_peak) begin
            if (first_reg)
               nslope_next = 1'b1;  // RQ8 RQ13
            else
               first_next  = 1'b1;  // RQ7
         end else begin
            first_next = 1'b0;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         peak_reg   <= 10'h000;  // RQ25
         first_reg  <= 1'b0;
         nslope_reg <= 1'b0;
      end else begin
         peak_reg   <= peak_next;
         first_reg  <= first_next;
         nslope_reg <= nslope_next;
      end
   end

   // Trickle latch from slope detection, and the fast/trickle decision
   logic trk_reg, trk_next;

   always_comb begin
      // Set wins over a reset event in the same cycle
      trk_next  = (trk_reg & ~rst_evt) | (nslope_reg & hold_done);  // RQ8 RQ10 RQ13
      fast_next = I_SENSE_IN_WINDOW                  // RQ23
                & ~trk_reg                           // RQ8
                & ~lnk.bt_expired                    // RQ18
                & ~(temp_mode & I_UNDER_TEMP)        // RQ20
                & ~ot_reg;                           // RQ21
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         trk_reg  <= 1'b0;
         fast_reg <= 1'b1;  // RQ25
      end else begin
         trk_reg  <= trk_next;
         fast_reg <= fast_next;
      end
   end

   // Backup timer control
   assign lnk.bt_clear = rst_evt;   // RQ23 RQ26
   assign lnk.bt_run   = fast_reg;  // RQ26
   assign lnk.bt_code  = prog_code; // RQ16

   // Open-collector pins: enable high pulls the pin low
   assign O_SENSE_GATE_OUT    = 1'b0;
   assign O_SENSE_GATE_OE     = lnk.gate_low;  // RQ3
   assign O_FAST_TRICKLE_OUT  = 1'b0;
   assign O_FAST_TRICKLE_OE   = ~fast_reg;
   assign O_NEG_SLOPE         = nslope_reg;
   assign O_FIRST_EVENT       = first_reg;
   assign O_TIMER_MODE        = time_mode;
   assign O_OVER_TEMP_LATCHED = ot_reg;
   assign O_PEAK_COUNT        = peak_reg;
endmodule
`default_nettype wire

/* verif/ctl_charge_term_sva.sv */
// Port-level concurrent checks for the charge termination controller
`default_nettype none
module ctl_charge_term_sva
   import ctl_pkg::*;
#(
   parameter logic [31:0] P_PERIOD_CYC  = GATE_PERIOD_CYC,
   parameter logic [31:0] P_PRESET_CYC  = PRESET_CYC,
   parameter logic [31:0] P_CONVERT_CYC = CONVERT_CYC
) (
   input wire logic       I_SYS_CLK,
   input wire logic       I_RST,
   input wire logic       I_SENSE_IN_WINDOW,
   input wire logic       I_SENSE_UNDER,
   input wire logic       I_UNDER_TEMP,
   input wire logic       I_OVER_TEMP,
   input wire logic       O_SAMPLE_CLK,
   input wire logic       O_SENSE_GATE_OE,
   input wire logic       O_FAST_TRICKLE_OE,
   input wire logic       O_NEG_SLOPE,
   input wire logic       O_FIRST_EVENT,
   input wire logic       O_TIMER_MODE,
   input wire logic       O_OVER_TEMP_LATCHED,
   input wire logic [9:0] O_PEAK_COUNT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] sck_cnt_reg, hi_cnt_reg, per_cnt_reg;
   logic        sck_d_reg, gate_d_reg, arm_reg, arm_s_reg;
   // Edge counters for clock and gate timing
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         sck_cnt_reg <= '0;
         hi_cnt_reg  <= '0;
         per_cnt_reg <= '0;
         sck_d_reg   <= 1'b0;
         gate_d_reg  <= 1'b1;
         arm_reg     <= 1'b0;
         arm_s_reg   <= 1'b0;
      end else begin
         sck_d_reg   <= O_SAMPLE_CLK;
         gate_d_reg  <= O_SENSE_GATE_OE;
         sck_cnt_reg <= (O_SAMPLE_CLK != sck_d_reg) ? 32'h1 : sck_cnt_reg + 32'h1;
         hi_cnt_reg  <= O_SENSE_GATE_OE ? hi_cnt_reg + 32'h1 : 32'h0;
         per_cnt_reg <= (O_SENSE_GATE_OE && !gate_d_reg) ? 32'h1 : per_cnt_reg + 32'h1;
         arm_reg     <= arm_reg | (O_SENSE_GATE_OE && !gate_d_reg);
         arm_s_reg   <= arm_s_reg | (O_SAMPLE_CLK != sck_d_reg);
      end
   end
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   sequence s_conv_end;
      !$past(O_SENSE_GATE_OE) && $past(O_SENSE_GATE_OE, 2);
   endsequence
   sequence s_hot;
      !O_TIMER_MODE && I_OVER_TEMP;
   endsequence
   a_sck_half_period: assert property (
      arm_s_reg && $changed(O_SAMPLE_CLK) |-> sck_cnt_reg == 32'(SCK_HALF_CYC))
      else $error("sample clock half period off");
   a_gate_low_len: assert property (
      arm_reg && $fell(O_SENSE_GATE_OE) |-> hi_cnt_reg == P_PRESET_CYC + P_CONVERT_CYC)
      else $error("gate low time off");
   a_gate_repeat: assert property (
      arm_reg && $rose(O_SENSE_GATE_OE) |-> per_cnt_reg == P_PERIOD_CYC)
      else $error("gate repetition off");
   a_peak_at_conv: assert property (
      $changed(O_PEAK_COUNT) && O_PEAK_COUNT != 10'h000 |-> s_conv_end)
      else $error("peak moved outside conversion end");
   a_slope_after_first: assert property (
      $rose(O_NEG_SLOPE) |-> ($past(O_FIRST_EVENT) and s_conv_end))
      else $error("slope without prior event");
   a_under_clears: assert property (
      I_SENSE_UNDER |=> O_PEAK_COUNT == 10'h000 && !O_FIRST_EVENT && !O_NEG_SLOPE)
      else $error("under-voltage did not clear detection");
   a_cold_trickle: assert property (
      !O_TIMER_MODE && I_UNDER_TEMP |=> O_FAST_TRICKLE_OE)
      else $error("cold pack not in trickle");
   a_hot_latch_trickle: assert property (
      s_hot |=> O_OVER_TEMP_LATCHED ##1 O_FAST_TRICKLE_OE)
      else $error("hot pack latch or trickle missing");
   a_hot_latch_holds: assert property (
      O_OVER_TEMP_LATCHED && !$rose(I_SENSE_IN_WINDOW) |=> O_OVER_TEMP_LATCHED)
      else $error("hot latch cleared without reset event");
endmodule
bind ctl_charge_term ctl_charge_term_sva #(
   .P_PERIOD_CYC(P_PERIOD_CYC), .P_PRESET_CYC(P_PRESET_CYC), .P_CONVERT_CYC(P_CONVERT_CYC)
) ctl_charge_term_sva_inst (
   .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_SENSE_IN_WINDOW(I_SENSE_IN_WINDOW),
   .I_SENSE_UNDER(I_SENSE_UNDER), .I_UNDER_TEMP(I_UNDER_TEMP), .I_OVER_TEMP(I_OVER_TEMP),
   .O_SAMPLE_CLK(O_SAMPLE_CLK), .O_SENSE_GATE_OE(O_SENSE_GATE_OE),
   .O_FAST_TRICKLE_OE(O_FAST_TRICKLE_OE), .O_NEG_SLOPE(O_NEG_SLOPE),
   .O_FIRST_EVENT(O_FIRST_EVENT), .O_TIMER_MODE(O_TIMER_MODE),
   .O_OVER_TEMP_LATCHED(O_OVER_TEMP_LATCHED), .O_PEAK_COUNT(O_PEAK_COUNT)
);
`default_nettype wire

/* verif/ctl_pack_model.sv */
// Pack and converter model: emits a set number of pulses per gated sample
`default_nettype none
module ctl_pack_model #(
   parameter int P_SETTLE_CYC = 600
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_sample_clk,
   input  wire logic       i_gate_oe,
   input  wire logic [3:0] i_target,
   output logic            o_vfc_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   int   gate_cnt;
   int   emitted;
   logic sck_d;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_vfc_pulse <= 1'b0;
         gate_cnt    <= 0;
         emitted     <= 0;
         sck_d       <= 1'b0;
      end else begin
         sck_d <= i_sample_clk;
         if (!i_gate_oe) begin
            gate_cnt    <= 0;
            emitted     <= 0;
            o_vfc_pulse <= 1'b0;
         end else begin
            gate_cnt <= gate_cnt + 1;
            // Toggle on sample clock falls only, so each rise meets one tick
            if (sck_d && !i_sample_clk && gate_cnt > P_SETTLE_CYC) begin
               if (o_vfc_pulse) begin
                  o_vfc_pulse <= 1'b0;
               end else if (emitted < int'(i_target)) begin
                  o_vfc_pulse <= 1'b1;
                  emitted     <= emitted + 1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verif/ctl_charge_term_bench.sv */
// Self-checking bench for the charge termination controller
`default_nettype none
module ctl_charge_term_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PER = 11000;
   localparam int PRE = 500;
   localparam int MIN = 10;
   logic       clk, rst, volt_to_freq_converter, win, und, lo, se, hi, ut, ot;
   logic       sck, g_out, g_oe, ft_out, ft_oe, slope, first, tmode, otl;
   logic [3:0] tgt;
   logic [9:0] peak;
   int         n_errors = 0;
   int         check_count = 0;

   ctl_charge_term #(
      .P_PERIOD_CYC(32'(PER)), .P_PRESET_CYC(32'(PRE)), .P_CONVERT_CYC(32'h2710),
      .P_START_CYC(40'h7d0), .P_HOLD_CYC(40'hea60), .P_MINUTE_CYC(32'(MIN))
   ) ctl_charge_term_inst (
      .I_SYS_CLK(clk), .I_RST(rst), .I_VFC_PULSE(volt_to_freq_converter), .I_SENSE_IN_WINDOW(win),
      .I_SENSE_UNDER(und), .I_LOW_REF_PROG_HIGH(lo), .I_SENSE_PROG_HIGH(se),
      .I_HIGH_REF_PROG_HIGH(hi), .I_UNDER_TEMP(ut), .I_OVER_TEMP(ot),
      .O_SAMPLE_CLK(sck), .O_SENSE_GATE_OUT(g_out), .O_SENSE_GATE_OE(g_oe),
      .O_FAST_TRICKLE_OUT(ft_out), .O_FAST_TRICKLE_OE(ft_oe), .O_NEG_SLOPE(slope),
      .O_FIRST_EVENT(first), .O_TIMER_MODE(tmode), .O_OVER_TEMP_LATCHED(otl),
      .O_PEAK_COUNT(peak)
   );
   ctl_pack_model #(.P_SETTLE_CYC(PRE + 20)) ctl_pack_model_inst (
      .i_clk(clk), .i_rst(rst), .i_sample_clk(sck), .i_gate_oe(g_oe),
      .i_target(tgt), .o_vfc_pulse(volt_to_freq_converter)
   );

   always #10 clk = ~clk;

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chkv(input string nm, input logic [9:0] e, input logic [9:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_fall;
      logic p;
      p = g_oe;
      for (int k = 0; k < 2 * PER; k++) begin
         @(posedge clk);
         #1;
         if (p === 1'b1 && g_oe === 1'b0) return;
         p = g_oe;
      end
      n_errors++;
      $display("[ERR] gate fall wait exceeded");
      report_and_stop();
   endtask
   task automatic reset_event;
      @(posedge clk);
      win <= 1'b0;
      cyc(2);
      @(posedge clk);
      win <= 1'b1;
   endtask
   task automatic sample(input logic [3:0] n);
      @(posedge clk);
      tgt <= n;
      wait_fall();
      cyc(5);
   endtask
   task automatic t_reset;
      cyc(1);
      chk1("fast_trickle_oe", 1'b0, ft_oe);
      chkv("peak", 10'h000, peak);
      chk1("first", 1'b0, first);
      chk1("ot_latched", 1'b0, otl);
      chk1("pins_out", 1'b0, g_out | ft_out);
   endtask
   task automatic t_timer_mode;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         {lo, se, hi} <= 3'(c);
         @(negedge clk);
         chk1("timer_mode", c != 0, tmode);
      end
   endtask
   task automatic t_backup;
      int lim [7] = '{71, 106, 141, 177, 212, 247, 283};
      for (int c = 7; c > 0; c--) begin
         @(posedge clk);
         {lo, se, hi} <= 3'(c);
         reset_event();
         cyc(lim[c - 1] * MIN - 15);
         chk1("fast within limit", 1'b0, ft_oe);
         cyc(30);
         chk1("trickle past limit", 1'b1, ft_oe);
      end
      @(posedge clk);
      {lo, se, hi} <= 3'h7;
      cyc(10);
      chk1("expiry latched", 1'b1, ft_oe);
      @(posedge clk);
      {lo, se, hi} <= 3'h0;
      reset_event();
      cyc(3);
      chk1("fast after window entry", 1'b0, ft_oe);
   endtask
   task automatic t_temp;
      @(posedge clk);
      ut <= 1'b1;
      cyc(3);
      chk1("cold trickle", 1'b1, ft_oe);
      @(posedge clk);
      ut <= 1'b0;
      cyc(3);
      chk1("warm fast", 1'b0, ft_oe);
      @(posedge clk);
      ot <= 1'b1;
      @(posedge clk);
      ot <= 1'b0;
      cyc(50);
      chk1("hot latch held", 1'b1, otl);
      chk1("hot trickle held", 1'b1, ft_oe);
      reset_event();
      cyc(3);
      chk1("hot latch cleared", 1'b0, otl);
      chk1("fast again", 1'b0, ft_oe);
   endtask
   task automatic t_slope;
      wait_fall();
      reset_event();
      sample(4'h6);
      chkv("peak first", 10'h006, peak);
      sample(4'h3);
      chk1("first event", 1'b1, first);
      chk1("still fast", 1'b0, ft_oe);
      sample(4'h7);
      chkv("peak raised", 10'h007, peak);
      chk1("event broken", 1'b0, first);
      sample(4'h4);
      chk1("first again", 1'b1, first);
      sample(4'h4);
      chk1("slope", 1'b1, slope);
      chk1("fast in holdoff", 1'b0, ft_oe);
      cyc(5010);
      chk1("trickle full", 1'b1, ft_oe);
   endtask
   task automatic t_under;
      @(posedge clk);
      win <= 1'b0;
      und <= 1'b1;
      cyc(3);
      chkv("peak cleared", 10'h000, peak);
      chk1("slope cleared", 1'b0, slope);
      chk1("first cleared", 1'b0, first);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      tgt = 4'h0;
      {win, und, lo, se, hi, ut, ot} = '0;
      cyc(4);
      t_reset();
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      win <= 1'b1;
      cyc(3);
      chk1("fast at start", 1'b0, ft_oe);
      t_timer_mode();
      t_backup();
      t_temp();
      t_slope();
      t_under();
      report_and_stop();
   end
endmodule
`default_nettype wire
